// ### inc/php_pkg.sv
// Constants for the per-port high-power register group of a four-port PSE controller.
// Assumes a register access port run by the serial interface logic on the same clock.
package php_pkg;

  localparam int PORT_COUNT = 4;

  // Register offsets, one entry per port, port 1 in entry 0.
  localparam logic [3:0][7:0] OVC_CFG_OFFSET = {8'h56, 8'h51, 8'h4c, 8'h47};
  localparam logic [3:0][7:0] LIM_CFG_OFFSET = {8'h57, 8'h52, 8'h4d, 8'h48};
  localparam logic [3:0][7:0] PORT1_HIGH_POWER_STATUS_OFFSET = {8'h58, 8'h53, 8'h4e, 8'h49};

  // Overcurrent configuration fields.
  localparam int SENSE_SCALE_BIT = 7;
  localparam int OVC_RANGE_BIT = 6;
  localparam int OVC_FIELD_MSB = 5;

  // Current-limit configuration fields.
  localparam int LIM_SELECT_BIT = 6;

  // High-power status fields.
  localparam int FAULT_FLAG_BIT = 1;
  localparam int CLASS_DONE_BIT = 0;

  // Values after reset.
  localparam logic [7:0] OVC_RESET_AUTO = 8'hd4;
  localparam logic [7:0] OVC_RESET_MANUAL = 8'h14;
  localparam logic [7:0] LIM_RESET = 8'h80;
  localparam logic [7:0] PORT1_HIGH_POWER_STATUS_RESET = 8'h00;

  // Overcurrent step in microamps: one unit of the threshold output.
  localparam int OVC_STEP_FINE_UA = 18750;
  localparam int OVC_STEP_COARSE_UA = 37500;

  // Kinds of register hit by an address.
  typedef enum logic [1:0] {PHP_NONE, PHP_OVC, PHP_LIM, PHP_STATUS} php_kind_t;

  // Decodes an address against the registers of one port.
  function automatic php_kind_t php_decode(input logic [7:0] addr, input int port);
    php_kind_t kind;
    kind = PHP_NONE;
    if (addr == OVC_CFG_OFFSET[port]) begin
      kind = PHP_OVC;
    end else if (addr == LIM_CFG_OFFSET[port]) begin
      kind = PHP_LIM;
    end else if (addr == PORT1_HIGH_POWER_STATUS_OFFSET[port]) begin
      kind = PHP_STATUS;
    end
    return kind;
  endfunction

endpackage

// ### hw/php_regs.sv
// Per-port overcurrent, current-limit and high-power status registers for four PSE ports.
// Assumes the serial interface logic drives the register port on this clock, and that
// the analog port monitors drive their flags asynchronously to it.
`timescale 1ns/1ps
`default_nettype none

module php_regs
  import php_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  input wire logic auto_mode,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_write_data,
  input wire logic reg_read,
  output logic [7:0] reg_read_data,
  input wire logic [3:0] port_powered,
  input wire logic [3:0] port_in_current_limit,
  input wire logic [3:0] port_output_above_2v,
  input wire logic [3:0] port_two_event_class_ok,
  input wire logic [3:0] port_class5,
  output logic [3:0][5:0] overcurrent_threshold_field,
  output logic [3:0] overcurrent_range_select,
  output logic [3:0] sense_scale_select,
  output logic [3:0][7:0] overcurrent_units,
  output logic [3:0] current_limit_select
);

  logic [3:0][7:0] ovc_cfg;
  logic [3:0] lim_sel;
  logic [3:0] fault_flag;
  logic [3:0] class_done_flag;
  logic [15:0] sync_a;
  logic [15:0] sync_b;
  logic [15:0] sync_c;
  logic [15:0] monitor;
  logic [3:0] class_ok_prev;
  logic [3:0] fault_cond;
  logic [3:0] class_event;
  logic [3:0][1:0] status_bits;

  // Monitor flags cross three stages; a bit changes once the last two stages agree.
  always_ff @(posedge clock) begin
    if (reset) begin
      sync_a <= 16'h0000;
      sync_b <= 16'h0000;
      sync_c <= 16'h0000;
      monitor <= 16'h0000;
    end else if (clock_enable) begin
      sync_a <= {port_two_event_class_ok, port_output_above_2v, port_in_current_limit,
                 port_powered};
      sync_b <= sync_a;
      sync_c <= sync_b;
      for (int i = 0; i < 16; i++) begin
        if (sync_b[i] == sync_c[i]) begin
          monitor[i] <= sync_c[i];
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      class_ok_prev <= 4'h0;
    end else if (clock_enable) begin
      class_ok_prev <= monitor[15:12];
    end
  end

  assign fault_cond = monitor[3:0] & ~monitor[7:4] & monitor[11:8];
  assign class_event = monitor[15:12] & ~class_ok_prev;

  // Overcurrent configuration, loaded from the operating-mode strap at reset.
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int p = 0; p < PORT_COUNT; p++) begin
        ovc_cfg[p] <= auto_mode ? OVC_RESET_AUTO : OVC_RESET_MANUAL;
      end
    end else if (clock_enable && reg_write) begin
      for (int p = 0; p < PORT_COUNT; p++) begin
        if (php_decode(reg_addr, p) == PHP_OVC) begin
          ovc_cfg[p] <= reg_write_data;
        end
      end
    end
  end

  // Only the selection bit of the current-limit register is stored.
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int p = 0; p < PORT_COUNT; p++) begin
        lim_sel[p] <= LIM_RESET[LIM_SELECT_BIT];
      end
    end else if (clock_enable && reg_write) begin
      for (int p = 0; p < PORT_COUNT; p++) begin
        if (php_decode(reg_addr, p) == PHP_LIM) begin
          lim_sel[p] <= reg_write_data[LIM_SELECT_BIT];
        end
      end
    end
  end

  // Sticky flags: a write of zero clears, and a set in the same cycle wins.
  always_ff @(posedge clock) begin
    if (reset) begin
      fault_flag <= PORT1_HIGH_POWER_STATUS_RESET[3:0];
      class_done_flag <= PORT1_HIGH_POWER_STATUS_RESET[3:0];
    end else if (clock_enable) begin
      for (int p = 0; p < PORT_COUNT; p++) begin
        if (fault_cond[p]) begin
          fault_flag[p] <= 1'b1;
        end else if (reg_write && php_decode(reg_addr, p) == PHP_STATUS
                     && !reg_write_data[FAULT_FLAG_BIT]) begin
          fault_flag[p] <= 1'b0;
        end
        if (class_event[p]) begin
          class_done_flag[p] <= 1'b1;
        end else if (reg_write && php_decode(reg_addr, p) == PHP_STATUS
                     && !reg_write_data[CLASS_DONE_BIT]) begin
          class_done_flag[p] <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    for (int p = 0; p < PORT_COUNT; p++) begin
      status_bits[p] = {fault_flag[p], class_done_flag[p]};
    end
  end

  // Read data is registered; unmapped addresses read as zero.
  always_ff @(posedge clock) begin
    if (reset) begin
      reg_read_data <= 8'h00;
    end else if (clock_enable && reg_read) begin
      reg_read_data <= 8'h00;
      for (int p = 0; p < PORT_COUNT; p++) begin
        case (php_decode(reg_addr, p))
          PHP_OVC: reg_read_data <= ovc_cfg[p];
          PHP_LIM: reg_read_data <= {1'b1, lim_sel[p], 6'b00_0000};
          PHP_STATUS: reg_read_data <= {6'b00_0000, status_bits[p]};
          default: ;
        endcase
      end
    end
  end

  // overcurrent_units in 18.75mA units: coarse range and class 5 each double the field.
  always_ff @(posedge clock) begin
    if (reset) begin
      overcurrent_threshold_field <= '0;
      overcurrent_range_select <= 4'h0;
      sense_scale_select <= 4'h0;
      overcurrent_units <= '0;
      current_limit_select <= 4'h0;
    end else if (clock_enable) begin
      for (int p = 0; p < PORT_COUNT; p++) begin
        overcurrent_threshold_field[p] <= ovc_cfg[p][OVC_FIELD_MSB:0];
        overcurrent_range_select[p] <= ovc_cfg[p][OVC_RANGE_BIT];
        sense_scale_select[p] <= ovc_cfg[p][SENSE_SCALE_BIT];
        // Each doubling adds one to the shift, so both together multiply by four.
        overcurrent_units[p] <= {2'b00, ovc_cfg[p][OVC_FIELD_MSB:0]}
            << (2'(port_class5[p]) + 2'(!ovc_cfg[p][OVC_RANGE_BIT]));
        current_limit_select[p] <= lim_sel[p];
      end
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_check
    AST_STATUS_CLEAR: assert property (@(posedge clock) $fell(reset) |->
        !fault_flag[g] && !class_done_flag[g])
      else $error("status not clear after reset");
    AST_FAULT_SET: assert property (@(posedge clock) disable iff (reset)
        clock_enable && fault_cond[g] |=> fault_flag[g])
      else $error("fault flag not set");
    AST_CLASS_SET: assert property (@(posedge clock) disable iff (reset)
        clock_enable && class_event[g] |=> class_done_flag[g])
      else $error("class done flag not set");
    AST_RANGE_DOUBLE: assert property (@(posedge clock) disable iff (reset)
        !reset && clock_enable && !ovc_cfg[g][OVC_RANGE_BIT] && !port_class5[g] ##1 clock_enable
        |-> overcurrent_units[g] == {1'b0, $past(ovc_cfg[g][5:0]), 1'b0})
      else $error("coarse range not doubled");
    AST_FIELD_OUT: assert property (@(posedge clock) disable iff (reset)
        !reset && clock_enable
        |=> overcurrent_threshold_field[g] == $past(ovc_cfg[g][5:0]))
      else $error("threshold field mismatch");
    AST_LIMIT_OUT: assert property (@(posedge clock) disable iff (reset)
        clock_enable && reg_write && php_decode(reg_addr, g) == PHP_LIM ##1 clock_enable
        |=> current_limit_select[g] == $past(reg_write_data[6], 2))
      else $error("limit select not taken");
    AST_CLASS5_UNITS: assert property (@(posedge clock) disable iff (reset)
        !reset && clock_enable && port_class5[g] && ovc_cfg[g][OVC_RANGE_BIT]
        |=> overcurrent_units[g] == {1'b0, $past(ovc_cfg[g][5:0]), 1'b0})
      else $error("class 5 not doubled");
    AST_OVC_RESET: assert property (@(posedge clock) $fell(reset) |->
        ovc_cfg[g] == ($past(auto_mode) ? OVC_RESET_AUTO : OVC_RESET_MANUAL))
      else $error("overcurrent reset value wrong");
    AST_FLAG_HOLD: assert property (@(posedge clock) disable iff (reset)
        fault_flag[g] && !(reg_write && php_decode(reg_addr, g) == PHP_STATUS)
        |=> fault_flag[g])
      else $error("fault flag dropped");
  end

  AST_LIM_READ: assert property (@(posedge clock) disable iff (reset)
      clock_enable && reg_read && php_decode(reg_addr, 0) == PHP_LIM
      |=> reg_read_data[7] && reg_read_data[5:0] == 6'h00)
    else $error("hardwired limit bits wrong");

  COV_FAULT: cover property (@(posedge clock) disable iff (reset) fault_cond[1] ##1 fault_flag[1]);
  COV_CLASS: cover property (@(posedge clock) disable iff (reset) class_event[0]);
  COV_CLEAR: cover property (@(posedge clock) disable iff (reset) class_done_flag[0] ##1
      !class_done_flag[0]);

endmodule

`default_nettype wire

// ### testbench/php_host_model.sv
// Host model for the register port: single byte writes and reads.
// Assumes the device takes a strobe at a rising edge and answers one cycle later.
`timescale 1ns/1ps
`default_nettype none
module php_host_model
  import php_pkg::*;
(
  input wire logic clock,
  input wire logic [7:0] reg_read_data,
  output logic [7:0] reg_addr,
  output logic reg_write,
  output logic [7:0] reg_write_data,
  output logic reg_read
);
  initial begin
    reg_addr = 8'h00;
    reg_write = 1'b0;
    reg_write_data = 8'h00;
    reg_read = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    for (int p = 0; p < PORT_COUNT; p++) begin
      if (a == OVC_CFG_OFFSET[p]) v[SENSE_SCALE_BIT] = 1'b0 | 1'b1;
    end
    @(posedge clock);
    reg_addr <= a;
    reg_write_data <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_write_data <= ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
    d = reg_read_data;
  endtask
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the per-port high-power register group.
// Assumes the host model drives the register port; monitor levels are driven here.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import php_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic auto_mode = 1'b1;
  logic ce = 1'b1;
  logic [3:0] powered = 4'h0;
  logic [3:0] in_limit = 4'h0;
  logic [3:0] above = 4'h0;
  logic [3:0] class_ok = 4'h0;
  logic [3:0] class5 = 4'h0;
  logic [7:0] addr, wdata, rdata, got;
  logic wr_en, rd_en;
  logic [3:0][5:0] field;
  logic [3:0] range, scale, lim_sel;
  logic [3:0][7:0] units;
  int num_errors = 0;
  int checks_done = 0;
  always #50 clock = ~clock;
  php_regs dut (.clock(clock), .reset(reset), .clock_enable(ce), .auto_mode(auto_mode),
    .reg_addr(addr), .reg_write(wr_en), .reg_write_data(wdata), .reg_read(rd_en),
    .reg_read_data(rdata), .port_powered(powered), .port_in_current_limit(in_limit),
    .port_output_above_2v(above), .port_two_event_class_ok(class_ok), .port_class5(class5),
    .overcurrent_threshold_field(field), .overcurrent_range_select(range),
    .sense_scale_select(scale), .overcurrent_units(units), .current_limit_select(lim_sel));
  php_host_model host (.clock(clock), .reg_read_data(rdata), .reg_addr(addr),
    .reg_write(wr_en), .reg_write_data(wdata), .reg_read(rd_en));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, got);
    chk(got, e);
  endtask
  task automatic do_reset(input logic am);
    @(posedge clock);
    auto_mode <= am;
    reset <= 1'b1;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    do_reset(1'b1);
    for (int p = 0; p < PORT_COUNT; p++) begin
      rchk(OVC_CFG_OFFSET[p], 8'hd4);
      rchk(LIM_CFG_OFFSET[p], 8'h80);
      rchk(PORT1_HIGH_POWER_STATUS_OFFSET[p], 8'h00);
    end
    rchk(8'h4a, 8'h00);
    $display("test reset values done");
    host.wr(OVC_CFG_OFFSET[2], 8'h0a);
    repeat (2) @(posedge clock);
    chk({2'b00, field[2]}, 8'h0a);
    chk({6'h00, scale[2], range[2]}, 8'h02);
    chk(units[2], 8'h14);
    class5 <= 4'h4;
    repeat (2) @(posedge clock);
    chk(units[2], 8'h28);
    host.wr(OVC_CFG_OFFSET[2], 8'hff);
    repeat (2) @(posedge clock);
    chk(units[2], 8'h7e);
    rchk(OVC_CFG_OFFSET[2], 8'hff);
    // A write while the clock enable is low must leave the register untouched.
    ce <= 1'b0;
    host.wr(OVC_CFG_OFFSET[1], 8'h55);
    ce <= 1'b1;
    rchk(OVC_CFG_OFFSET[1], 8'hd4);
    $display("test overcurrent done");
    host.wr(LIM_CFG_OFFSET[3], 8'h7f);
    rchk(LIM_CFG_OFFSET[3], 8'hc0);
    chk({7'h00, lim_sel[3]}, 8'h01);
    host.wr(LIM_CFG_OFFSET[3], 8'hbf);
    rchk(LIM_CFG_OFFSET[3], 8'h80);
    chk({7'h00, lim_sel[3]}, 8'h00);
    $display("test current limit done");
    powered <= 4'h2;
    in_limit <= 4'h2;
    above <= 4'h2;
    repeat (10) @(posedge clock);
    rchk(PORT1_HIGH_POWER_STATUS_OFFSET[1], 8'h00);
    in_limit <= 4'h0;
    repeat (10) @(posedge clock);
    above <= 4'h0;
    repeat (10) @(posedge clock);
    rchk(PORT1_HIGH_POWER_STATUS_OFFSET[1], 8'h02);
    host.wr(PORT1_HIGH_POWER_STATUS_OFFSET[1], 8'hfd);
    rchk(PORT1_HIGH_POWER_STATUS_OFFSET[1], 8'h00);
    $display("test fault flag done");
    for (int n = 0; n < 2; n++) begin
      class_ok <= 4'h1;
      repeat (10) @(posedge clock);
      class_ok <= 4'h0;
      repeat (10) @(posedge clock);
      rchk(PORT1_HIGH_POWER_STATUS_OFFSET[0], 8'h01);
      host.wr(PORT1_HIGH_POWER_STATUS_OFFSET[0], 8'hfe);
      rchk(PORT1_HIGH_POWER_STATUS_OFFSET[0], 8'h00);
    end
    class_ok <= 4'h8;
    repeat (10) @(posedge clock);
    class_ok <= 4'h0;
    repeat (10) @(posedge clock);
    rchk(PORT1_HIGH_POWER_STATUS_OFFSET[3], 8'h01);
    do_reset(1'b0);
    rchk(PORT1_HIGH_POWER_STATUS_OFFSET[3], 8'h00);
    rchk(OVC_CFG_OFFSET[3], 8'h14);
    $display("test class flag and reset done");
    final_report();
  end
  initial begin
    repeat (3000) @(posedge clock);
    num_errors++;
    final_report();
  end
endmodule
`default_nettype wire
